// ==== src/ips_map.vh ====
/*
 * constants for the input protection sequencer: timing figures, derived cycle
 * counts and the soft-start staircase shape.
 * assumes a 250 MHz mclk and comparator inputs that are already digital levels.
 */
`ifndef IPS_MAP_VH
`define IPS_MAP_VH

`define IPS_CLK_MHZ 250
// times in microseconds
`define IPS_STEP_TIME_US 625
`define IPS_SHORT_CHECK_TIME_US 5000
`define IPS_SHORT_RECOVERY_TIME_US 100000
`define IPS_POWER_GOOD_DEGLITCH_TIME_US 8000
`define IPS_OV_RECOVERY_TIME_US 8000
`define IPS_BAT_OV_DEGLITCH_TIME_US 200
`define IPS_SOFT_STOP_STEP_TIME_US 10
// cycle counts
`define IPS_STEP_CYC (`IPS_STEP_TIME_US * `IPS_CLK_MHZ)
`define IPS_SHORT_CHECK_CYC (`IPS_SHORT_CHECK_TIME_US * `IPS_CLK_MHZ)
`define IPS_SHORT_RECOVERY_CYC (`IPS_SHORT_RECOVERY_TIME_US * `IPS_CLK_MHZ)
`define IPS_POWER_GOOD_DEGLITCH_CYC (`IPS_POWER_GOOD_DEGLITCH_TIME_US * `IPS_CLK_MHZ)
`define IPS_OV_RECOVERY_CYC (`IPS_OV_RECOVERY_TIME_US * `IPS_CLK_MHZ)
`define IPS_BAT_OV_DEGLITCH_CYC (`IPS_BAT_OV_DEGLITCH_TIME_US * `IPS_CLK_MHZ)
`define IPS_SOFT_STOP_STEP_CYC (`IPS_SOFT_STOP_STEP_TIME_US * `IPS_CLK_MHZ)
// staircase
`define IPS_NUM_STEPS 8
`define IPS_LIMIT_W 4

`endif

// ==== src/ips_sequencer.v ====
/*
 * control sequencer of the input protection switch: start-up, soft-start
 * staircase, start-up short-circuit check and retry, soft-stop and the fault
 * output. assumes comparators arrive as asynchronous levels, one mclk.
 */
`timescale 1ns/1ps
`include "ips_map.vh"
module ips_sequencer #(
    parameter STEP_CYC = `IPS_STEP_CYC,
    parameter SHORT_CHECK_CYC = `IPS_SHORT_CHECK_CYC,
    parameter SHORT_RECOVERY_CYC = `IPS_SHORT_RECOVERY_CYC,
    parameter POWER_GOOD_DEGLITCH_CYC = `IPS_POWER_GOOD_DEGLITCH_CYC,
    parameter OV_RECOVERY_CYC = `IPS_OV_RECOVERY_CYC,
    parameter BAT_OV_DEGLITCH_CYC = `IPS_BAT_OV_DEGLITCH_CYC,
    parameter SOFT_STOP_STEP_CYC = `IPS_SOFT_STOP_STEP_CYC,
    parameter LIMIT_W = `IPS_LIMIT_W
)(
    // clock and reset
    input wire mclk,
    input wire rstn,
    // comparator inputs, asynchronous levels
    input wire undervoltage_lockout,
    input wire input_overvoltage,
    input wire battery_overvoltage,
    input wire over_temperature,
    input wire overcurrent,
    // host enable, active low
    input wire chip_enable_n,
    // pass switch control
    output reg pass_on_q,
    output reg [LIMIT_W-1:0] current_limit_q,
    output reg current_monitor_en_q,
    output reg [LIMIT_W-1:0] gate_drive_q,
    // open-drain fault, oe low means driving low
    output reg fault_n_out_q,
    output reg fault_n_oe_n_q
);
    localparam CW = 32;
    localparam [2:0] ST_OFF = 3'd0;
    localparam [2:0] ST_PGOOD = 3'd1;
    localparam [2:0] ST_SSTART = 3'd2;
    localparam [2:0] ST_CHECK = 3'd3;
    localparam [2:0] ST_SSTOP = 3'd4;
    localparam [2:0] ST_RECOVER = 3'd5;
    localparam [2:0] ST_NORMAL = 3'd6;
    localparam [2:0] ST_FAULT = 3'd7;
    localparam [LIMIT_W-1:0] FULL = `IPS_NUM_STEPS;

    // ----------------------------------------
    // input conditioning
    // ----------------------------------------
    wire undervoltage_lockout_s;
    wire iov_s;
    wire bov_s;
    wire ot_s;
    wire oc_s;
    wire ce_n_s;
    ips_sync_filter #(.CYCLES(1), .CW(CW), .RESET_VAL(1'b1)) u_undervoltage_lockout (
        .mclk(mclk), .rstn(rstn), .raw_in(undervoltage_lockout), .level_q(undervoltage_lockout_s));
    ips_sync_filter #(.CYCLES(1), .CW(CW), .RESET_VAL(1'b0)) u_iov (
        .mclk(mclk), .rstn(rstn), .raw_in(input_overvoltage), .level_q(iov_s));
    // battery ov must persist for its deglitch before it counts
    ips_sync_filter #(.CYCLES(BAT_OV_DEGLITCH_CYC), .CW(CW), .RESET_VAL(1'b0)) u_bov (
        .mclk(mclk), .rstn(rstn), .raw_in(battery_overvoltage), .level_q(bov_s));
    ips_sync_filter #(.CYCLES(1), .CW(CW), .RESET_VAL(1'b0)) u_ot (
        .mclk(mclk), .rstn(rstn), .raw_in(over_temperature), .level_q(ot_s));
    ips_sync_filter #(.CYCLES(1), .CW(CW), .RESET_VAL(1'b0)) u_oc (
        .mclk(mclk), .rstn(rstn), .raw_in(overcurrent), .level_q(oc_s));
    ips_sync_filter #(.CYCLES(1), .CW(CW), .RESET_VAL(1'b1)) u_ce (
        .mclk(mclk), .rstn(rstn), .raw_in(chip_enable_n), .level_q(ce_n_s));

    // ----------------------------------------
    // state and timers
    // ----------------------------------------
    reg [2:0] st_q;
    reg [2:0] st_d;
    reg [CW-1:0] tmr_q;
    reg [CW-1:0] tmr_d;
    reg short_q;
    reg short_d;
    reg ov_wait_q;
    reg ov_wait_d;
    reg [LIMIT_W-1:0] lim_d;
    reg [LIMIT_W-1:0] gate_d;
    reg mon_d;

    // voltage and thermal causes; a lone battery ov soft-stops, except in the short recovery state, where it faults
    wire hard_fault = iov_s | bov_s | ot_s;
    wire disabled = undervoltage_lockout_s | ce_n_s;

    function expired;
        input [CW-1:0] t;
        input [CW-1:0] lim;
        begin
            expired = (t >= lim - 1);
        end
    endfunction

    always @*
    begin
        st_d = st_q;
        tmr_d = tmr_q + 1'b1;
        short_d = short_q;
        ov_wait_d = ov_wait_q;
        lim_d = current_limit_q;
        gate_d = gate_drive_q;
        mon_d = current_monitor_en_q;
        if (disabled)
        begin
            // lockout or host disable wipes every fault memory
            st_d = ST_OFF;
            short_d = 1'b0;
            ov_wait_d = 1'b0;
            lim_d = {LIMIT_W{1'b0}};
            gate_d = {LIMIT_W{1'b0}};
            mon_d = 1'b0;
        end
        else if (hard_fault && st_q != ST_FAULT && st_q != ST_OFF && st_q != ST_PGOOD &&
                 !(st_q == ST_SSTOP && !iov_s && !ot_s))
        begin
            if (!iov_s && !ot_s && st_q != ST_RECOVER)
            begin
                // battery ov ramps the gate down; monitor is left alone until the ramp ends
                st_d = ST_SSTOP;
                tmr_d = {CW{1'b0}};
            end
            else
            begin
                st_d = ST_FAULT;
                tmr_d = {CW{1'b0}};
                ov_wait_d = iov_s;
                lim_d = {LIMIT_W{1'b0}};
                gate_d = {LIMIT_W{1'b0}};
                mon_d = 1'b0;
            end
        end
        else
        begin
            case (st_q)
                ST_OFF:
                begin
                    st_d = ST_PGOOD;
                    tmr_d = {CW{1'b0}};
                end
                ST_PGOOD:
                begin
                    if (hard_fault)
                        tmr_d = {CW{1'b0}};
                    else if (expired(tmr_q, POWER_GOOD_DEGLITCH_CYC))
                    begin
                        st_d = ST_SSTART;
                        ov_wait_d = 1'b0;
                        tmr_d = {CW{1'b0}};
                        lim_d = {{(LIMIT_W-1){1'b0}}, 1'b1};
                        gate_d = {{(LIMIT_W-1){1'b0}}, 1'b1};
                        mon_d = 1'b1;
                    end
                end
                ST_SSTART:
                begin
                    if (expired(tmr_q, STEP_CYC))
                    begin
                        tmr_d = {CW{1'b0}};
                        if (current_limit_q == FULL)
                        begin
                            // staircase done: sample load current
                            if (oc_s)
                                st_d = ST_CHECK;
                            else
                            begin
                                st_d = ST_NORMAL;
                                mon_d = 1'b0;
                            end
                        end
                        else
                        begin
                            lim_d = current_limit_q + 1'b1;
                            gate_d = current_limit_q + 1'b1;
                        end
                    end
                end
                ST_CHECK:
                begin
                    if (!oc_s)
                    begin
                        st_d = ST_NORMAL;
                        mon_d = 1'b0;
                    end
                    else if (expired(tmr_q, SHORT_CHECK_CYC))
                    begin
                        st_d = ST_SSTOP;
                        short_d = 1'b1;
                        tmr_d = {CW{1'b0}};
                    end
                end
                ST_SSTOP:
                begin
                    // gradual gate ramp-down limits input spikes from cable inductance
                    if (gate_drive_q == {LIMIT_W{1'b0}})
                    begin
                        st_d = short_q ? ST_RECOVER : ST_FAULT;
                        tmr_d = {CW{1'b0}};
                        lim_d = {LIMIT_W{1'b0}};
                        mon_d = 1'b0;
                    end
                    else if (expired(tmr_q, SOFT_STOP_STEP_CYC))
                    begin
                        gate_d = gate_drive_q - 1'b1;
                        tmr_d = {CW{1'b0}};
                    end
                end
                ST_RECOVER:
                begin
                    if (expired(tmr_q, SHORT_RECOVERY_CYC))
                    begin
                        st_d = ST_SSTART;
                        short_d = 1'b0;
                        tmr_d = {CW{1'b0}};
                        lim_d = {{(LIMIT_W-1){1'b0}}, 1'b1};
                        gate_d = {{(LIMIT_W-1){1'b0}}, 1'b1};
                        mon_d = 1'b1;
                    end
                end
                ST_NORMAL:
                begin
                    gate_d = FULL;
                    lim_d = FULL;
                end
                ST_FAULT:
                begin
                    if (hard_fault)
                        tmr_d = {CW{1'b0}};
                    else if (!ov_wait_q || expired(tmr_q, OV_RECOVERY_CYC))
                    begin
                        st_d = ST_SSTART;
                        ov_wait_d = 1'b0;
                        tmr_d = {CW{1'b0}};
                        lim_d = {{(LIMIT_W-1){1'b0}}, 1'b1};
                        gate_d = {{(LIMIT_W-1){1'b0}}, 1'b1};
                        mon_d = 1'b1;
                    end
                end
                default:
                    st_d = ST_OFF;
            endcase
        end
        if (iov_s && !disabled)
            ov_wait_d = 1'b1;
    end

    // ----------------------------------------
    // registers and outputs
    // ----------------------------------------
    wire on_d = (st_d == ST_SSTART) || (st_d == ST_CHECK) ||
                (st_d == ST_SSTOP) || (st_d == ST_NORMAL);
    // fault only while enabled and above lockout; ov is off one cycle before fault
    wire fault_d = !disabled && (short_d || (st_q == ST_FAULT && hard_fault) ||
                   (bov_s && (st_d == ST_SSTOP || st_d == ST_FAULT)) ||
                   (st_q == ST_FAULT && st_d == ST_FAULT));

    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= ST_OFF;
            tmr_q <= {CW{1'b0}};
            short_q <= 1'b0;
            ov_wait_q <= 1'b0;
            pass_on_q <= 1'b0;
            current_limit_q <= {LIMIT_W{1'b0}};
            gate_drive_q <= {LIMIT_W{1'b0}};
            current_monitor_en_q <= 1'b0;
            fault_n_out_q <= 1'b0;
            fault_n_oe_n_q <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            short_q <= short_d;
            ov_wait_q <= ov_wait_d;
            pass_on_q <= on_d && !disabled && (!hard_fault || st_d == ST_SSTOP);
            current_limit_q <= lim_d;
            gate_drive_q <= gate_d;
            current_monitor_en_q <= mon_d;
            fault_n_out_q <= 1'b0;
            fault_n_oe_n_q <= !fault_d;
        end
    end
endmodule // ips_sequencer

// ==== src/ips_sync_filter.v ====
/*
 * two-flop synchroniser followed by a deglitch counter: the output follows the
 * input only after it has been stable for the given number of cycles.
 * assumes an asynchronous comparator level on its input.
 */
`timescale 1ns/1ps
module ips_sync_filter #(
    parameter CYCLES = 1,
    parameter CW = 32,
    parameter RESET_VAL = 1'b0
)(
    // clock and reset
    input wire mclk,
    input wire rstn,
    // level in and out
    input wire raw_in,
    output reg level_q
);
    reg meta_q;
    reg sync_q;
    reg [CW-1:0] cnt_q;

    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
            level_q <= RESET_VAL;
            cnt_q <= {CW{1'b0}};
        end
        else
        begin
            meta_q <= raw_in;
            sync_q <= meta_q;
            if (sync_q == level_q)
                cnt_q <= {CW{1'b0}};
            else if (cnt_q >= CYCLES[CW-1:0] - 1'b1)
            begin
                level_q <= sync_q;
                cnt_q <= {CW{1'b0}};
            end
            else
                cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule // ips_sync_filter

// ==== test/ips_host_model.sv ====
/*
 host model: drives the enable, reads the fault pin.
 assumes a pull-up on the open-drain fault line.
*/
`timescale 1ns/1ps
module ips_host_model (
    // clock and command
    input wire mclk,
    input wire want_enable,
    // device pins
    input wire fault_n_out_q,
    input wire fault_n_oe_n_q,
    output reg chip_enable_n,
    output wire fault_pin
);
    // released line floats to the pull-up level
    assign fault_pin = fault_n_oe_n_q ? 1'b1 : fault_n_out_q;
    initial chip_enable_n = 1'b1;
    always @(posedge mclk)
        chip_enable_n <= #1 !want_enable;
endmodule // ips_host_model

// ==== test/ips_seq_asserts.sv ====
/*
 checker of the protection sequencer ports.
 assumes bind onto ips_sequencer, one clock.
*/
`timescale 1ns/1ps
module ips_seq_asserts #(
    parameter LIMIT_W = 4,
    parameter OV_RECOVERY_CYC = 30
)(
    // clock and reset
    input wire mclk,
    input wire rstn,
    // comparators and enable
    input wire undervoltage_lockout,
    input wire input_overvoltage,
    input wire battery_overvoltage,
    input wire over_temperature,
    input wire overcurrent,
    input wire chip_enable_n,
    // outputs
    input wire pass_on_q,
    input wire [LIMIT_W-1:0] current_limit_q,
    input wire current_monitor_en_q,
    input wire [LIMIT_W-1:0] gate_drive_q,
    input wire fault_n_out_q,
    input wire fault_n_oe_n_q
);
    // ----------------------------------------
    // cycles since input overvoltage was high
    // ----------------------------------------
    reg [7:0] quiet_q;
    wire en = !chip_enable_n && !undervoltage_lockout;
    always @(posedge mclk or negedge rstn)
        if (!rstn)
            quiet_q <= 8'h00;
        else if (input_overvoltage)
            quiet_q <= 8'h00;
        else if (quiet_q != 8'hff)
            quiet_q <= quiet_q + 8'h01;
    // cycles since battery overvoltage was high
    reg [3:0] bat_quiet_q;
    always @(posedge mclk or negedge rstn)
        if (!rstn)
            bat_quiet_q <= 4'h0;
        else if (battery_overvoltage)
            bat_quiet_q <= 4'h0;
        else if (bat_quiet_q != 4'hf)
            bat_quiet_q <= bat_quiet_q + 4'h1;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_lockout_off: assert property (undervoltage_lockout [*5] |=>
        !pass_on_q && fault_n_oe_n_q) else $error("lockout left switch on");
    a_enable_off: assert property (chip_enable_n [*5] |=>
        !pass_on_q && fault_n_oe_n_q) else $error("disable left switch on");
    a_start_hold: assert property ($rose(pass_on_q) |-> current_limit_q == 4'h1
        ##1 $stable(current_limit_q) [*8]) else $error("bad first step");
    a_step_size: assert property (pass_on_q && $past(pass_on_q) &&
        current_limit_q != $past(current_limit_q) |->
        current_limit_q == $past(current_limit_q) + 1'b1) else $error("bad step");
    a_soft_stop: assert property (pass_on_q && gate_drive_q < $past(gate_drive_q)
        |-> gate_drive_q == $past(gate_drive_q) - 1'b1) else $error("abrupt stop");
    a_ov_off: assert property (((input_overvoltage || over_temperature) && en) [*6]
        |-> !pass_on_q && !fault_n_oe_n_q) else $error("ov or heat not off");
    a_bat_off: assert property ((battery_overvoltage && en) [*8] ##1
        (battery_overvoltage && en) [*8] ##1 (battery_overvoltage && en) [*8] ##1
        (battery_overvoltage && en) [*8] ##1 (battery_overvoltage && en) [*8]
        |-> !pass_on_q && !fault_n_oe_n_q) else $error("battery ov not off");
    a_ov_recovery: assert property ($rose(pass_on_q) |->
        quiet_q >= OV_RECOVERY_CYC) else $error("early restart");
    a_normal_entry: assert property ($fell(current_monitor_en_q) && pass_on_q
        |-> current_limit_q == 4'h8 && gate_drive_q == 4'h8) else $error("bad normal");
    a_normal_clean: assert property (pass_on_q && !current_monitor_en_q &&
        bat_quiet_q == 4'hf |-> fault_n_oe_n_q) else $error("fault in normal");
    a_drive_low: assert property (fault_n_out_q == 1'b0)
        else $error("fault drive high");
endmodule // ips_seq_asserts

// ==== test/tb_top.sv ====
/*
 self-checking bench of the protection sequencer.
 assumes shortened timing parameters.
*/
`timescale 1ns/1ps
module tb_top;
    localparam STEP = 20;
    localparam OVREC = 30;
    localparam PGOOD = 30;
    localparam CHECK = 50;
    localparam RECOV = 100;
    localparam BATDG = 5;
    localparam SSTEP = 3;
    reg mclk = 1'b0;
    reg rstn = 1'b0;
    reg undervoltage_lockout = 1'b0;
    reg [2:0] cause = 3'h0;
    reg overcurrent = 1'b0;
    reg want_en = 1'b0;
    reg [3:0] prev;
    wire chip_enable_n, pass_on_q, current_monitor_en_q, fault_n_out_q, fault_n_oe_n_q;
    wire fault_pin;
    wire [3:0] current_limit_q, gate_drive_q;
    integer n_mismatch = 0;
    integer comparisons = 0;
    integer n, i, c;
    always #2 mclk = ~mclk;
    ips_host_model host_u (.mclk(mclk), .want_enable(want_en), .fault_n_out_q(fault_n_out_q),
        .fault_n_oe_n_q(fault_n_oe_n_q), .chip_enable_n(chip_enable_n), .fault_pin(fault_pin));
    ips_sequencer #(.STEP_CYC(STEP), .SHORT_CHECK_CYC(CHECK), .SHORT_RECOVERY_CYC(RECOV),
        .POWER_GOOD_DEGLITCH_CYC(PGOOD), .OV_RECOVERY_CYC(OVREC), .BAT_OV_DEGLITCH_CYC(BATDG),
        .SOFT_STOP_STEP_CYC(SSTEP)) dut_u (.mclk(mclk), .rstn(rstn),
        .undervoltage_lockout(undervoltage_lockout), .input_overvoltage(cause[0]),
        .battery_overvoltage(cause[2]), .over_temperature(cause[1]),
        .overcurrent(overcurrent), .chip_enable_n(chip_enable_n), .pass_on_q(pass_on_q),
        .current_limit_q(current_limit_q), .current_monitor_en_q(current_monitor_en_q),
        .gate_drive_q(gate_drive_q), .fault_n_out_q(fault_n_out_q),
        .fault_n_oe_n_q(fault_n_oe_n_q));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [7:0] exp_limit(input integer k);
        exp_limit = k + 1;
    endfunction
    function sig(input integer w);
        sig = (w == 0) ? pass_on_q : (w == 1) ? fault_pin :
            (w == 2) ? current_monitor_en_q : (current_limit_q != prev);
    endfunction
    task wrap_up;
    begin
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task chk(input [127:0] what, input [7:0] seen, input [7:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %0s: expected %0h, seen %0h", what, exp, seen);
        end
    end
    endtask
    task tick(input integer k);
    begin
        repeat (k) @(posedge mclk);
        #1;
    end
    endtask
    // bounded wait; a hang ends the run
    task wait_for(input integer w, input v, input integer bound, output integer cnt);
    begin
        cnt = 0;
        while (sig(w) !== v && cnt < bound)
        begin
            tick(1);
            cnt = cnt + 1;
        end
        if (sig(w) !== v)
        begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected timeout on wait %0d", w);
            wrap_up;
        end
    end
    endtask
    // switch-on, then every step spacing of the staircase
    task start_check(output integer dly);
        integer g;
    begin
        wait_for(0, 1'b1, 300, dly);
        chk("first_limit", current_limit_q, exp_limit(0));
        for (i = 1; i < 8; i = i + 1)
        begin
            prev = current_limit_q;
            wait_for(3, 1'b1, 60, g);
            chk("step_gap", g, STEP);
            chk("step_value", current_limit_q, exp_limit(i));
        end
    end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        n = $urandom(32'hfeb29d5b);
        tick(10);
        rstn = 1'b1;
        want_en = 1'b1;
        start_check(n);
        chk("pgood_wait", n >= PGOOD, 1);
        wait_for(2, 1'b0, 100, n);
        chk("fault_normal", fault_pin, 1);
        for (c = 0; c < 3; c = c + 1)
        begin
            cause = 3'h1 << c;
            if (c == 2)
            begin
                tick(12);
                chk("bat_soft", pass_on_q && gate_drive_q < 4'h8, 1);
                chk("bat_fault", fault_pin, 0);
            end
            wait_for(0, 1'b0, 60, n);
            tick(2);
            chk("fault_cause", fault_pin, 0);
            tick($urandom_range(40, 5));
            cause = 3'h0;
            start_check(n);
            if (c == 0)
                chk("ov_recovery", n >= OVREC, 1);
            wait_for(2, 1'b0, 100, n);
            chk("fault_clear", fault_pin, 1);
        end
        for (i = 0; i < 4; i = i + 1)
        begin
            cause = 3'h4;
            tick($urandom_range(3, 1));
            cause = 3'h0;
            tick(10);
            chk("bat_glitch", pass_on_q, 1);
        end
        cause = 3'h1;
        wait_for(1, 1'b0, 40, n);
        undervoltage_lockout = 1'b1;
        tick(8);
        chk("lockout_pass", pass_on_q, 0);
        chk("lockout_fault", fault_pin, 1);
        cause = 3'h0;
        undervoltage_lockout = 1'b0;
        start_check(n);
        chk("lockout_wait", n >= PGOOD, 1);
        want_en = 1'b0;
        tick(8);
        chk("disable_pass", pass_on_q, 0);
        chk("disable_fault", fault_pin, 1);
        overcurrent = 1'b1;
        want_en = 1'b1;
        start_check(n);
        wait_for(1, 1'b0, 200, n);
        chk("check_time", n >= CHECK, 1);
        chk("check_pass", pass_on_q, 1);
        wait_for(0, 1'b0, 100, n);
        wait_for(1, 1'b1, 400, n);
        chk("recovery", n >= RECOV, 1);
        start_check(n);
        overcurrent = 1'b0;
        wait_for(2, 1'b0, 200, n);
        chk("normal_limit", current_limit_q, 8);
        chk("normal_fault", fault_pin, 1);
        wrap_up;
    end
endmodule // tb_top
bind ips_sequencer ips_seq_asserts #(.LIMIT_W(LIMIT_W), .OV_RECOVERY_CYC(OV_RECOVERY_CYC))
    chk_u (.mclk(mclk), .rstn(rstn), .undervoltage_lockout(undervoltage_lockout),
    .input_overvoltage(input_overvoltage), .battery_overvoltage(battery_overvoltage),
    .over_temperature(over_temperature), .overcurrent(overcurrent),
    .chip_enable_n(chip_enable_n), .pass_on_q(pass_on_q), .current_limit_q(current_limit_q),
    .current_monitor_en_q(current_monitor_en_q), .gate_drive_q(gate_drive_q),
    .fault_n_out_q(fault_n_out_q), .fault_n_oe_n_q(fault_n_oe_n_q));
